// *** verif/output_three_rate_select_test.sv ***
// self-checking bench for the output three rate selector
`timescale 1ns/1ns

module output_three_rate_select_test;
    // ============================================================
    // signals
    logic clock, reset, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp;
    otrs_pkg::otrs_sel_t outSel;
    int n_fail = 0;
    int total_checks = 0;
    // divisors for codes 5..15; other codes report a divisor of one
    logic [6:0] divTab [16] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h30,
        7'h10, 7'h0c, 7'h08, 7'h06, 7'h04, 7'h40, 7'h20, 7'h10, 7'h08, 7'h04};
    // sources by code with ethernet mapping off
    logic [2:0] srcTab [16] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5,
        3'h5, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6};

    // ============================================================
    // clock at 250 MHz, hready fed back from the slave
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    otrs_top dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .outSel(outSel));

    // ============================================================
    // verdict, reached from the end of the run or from a timeout
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                got, exp);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            complete_run();
        end
    endtask

    // one single-word transfer; read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    // write, then wait two edges for the selection to settle
    task automatic wr_settle(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, a, wd, d);
        repeat (2) @(posedge clock);
        #1;
    endtask

    // ============================================================
    // scenarios
    task automatic test_reset();
        logic [31:0] d;
        chk({22'h0, outSel.source, outSel.divisor}, {25'h5, 7'h10}, "rst sel");
        bus(1'b0, 8'h00, 32'h0, d);
        chk(d, 32'h6, "rate reset");
        bus(1'b0, 8'h04, 32'h0, d);
        chk(d, 32'h0, "enet reset");
        $display("reset test done");
    endtask

    task automatic test_plain();
        for (int c = 0; c < 16; c++) begin
            wr_settle(8'h00, c);
            chk({29'h0, outSel.source}, {29'h0, srcTab[c]}, "src");
            chk({25'h0, outSel.divisor}, {25'h0, divTab[c]}, "div");
        end
        $display("plain mapping test done");
    endtask

    task automatic test_ether();
        wr_settle(8'h04, 32'h04);
        for (int c = 0; c < 16; c++) begin
            wr_settle(8'h00, c);
            chk({29'h0, outSel.source}, 32'h7, "eth src");
            chk({30'h0, outSel.ethRate}, c & 3, "eth rate");
            chk({31'h0, outSel.apllOn}, 32'h0, "apll off");
        end
        wr_settle(8'h04, 32'h00);
        chk({29'h0, outSel.source}, 32'h6, "back to aux");
        $display("ethernet mapping test done");
    endtask

    task automatic test_apll();
        logic [31:0] d;
        wr_settle(8'h04, 32'hffff_ffff);
        chk({31'h0, outSel.apllOn}, 32'h1, "apll on");
        bus(1'b0, 8'h04, 32'h0, d);
        chk(d, 32'h44, "enet readback");
        bus(1'b0, 8'h08, 32'h0, d);
        chk(d, {19'h0, 3'h7, 7'h01, 2'h3, 1'b1}, "status");
        wr_settle(8'h04, 32'h40);
        chk({29'h0, outSel.source}, 32'h6, "apll only");
        $display("apll test done");
    endtask

    task automatic test_unused();
        logic [31:0] d;
        wr_settle(8'h00, 32'hf1);
        bus(1'b0, 8'h00, 32'h0, d);
        chk(d, 32'h1, "upper bits");
        chk({29'h0, outSel.source}, 32'h1, "2k src");
        wr_settle(8'h0c, 32'hffff_ffff);
        bus(1'b0, 8'h0c, 32'h0, d);
        chk(d, 32'h0, "unmapped");
        chk({31'h0, hresp}, 32'h0, "okay");
        $display("unused bits test done");
    endtask

    // ============================================================
    // main sequence
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        test_reset();
        test_plain();
        test_ether();
        test_apll();
        test_unused();
        complete_run();
    end
endmodule // output_three_rate_select_test

// *** verilog/otrs_defines.svh ***
// offsets, field positions, reset values and divisors of the rate selector
//
// Overview of operation
// - ethernet select set: low bits pick ethernet rate
// - codes 0,1,2: off, 2 kHz, 8 kHz
// - codes 3,4: synth two, synth one
// - codes 7..10 divide main path by 12,8,6,4
// - divisors are fixed per code and ignore apll; codes 11..15 use aux path
// - ethernet config bit 6 enables ethernet apll
// - ethernet config bit 2 picks ethernet mapping
`ifndef OTRS_DEFINES_SVH
`define OTRS_DEFINES_SVH

// ============================================================
// register map
`define OTRS_RATE_OFFSET 8'h00
`define OTRS_ENET_OFFSET 8'h04
`define OTRS_STAT_OFFSET 8'h08
`define OTRS_ADDR_MSB 7
`define OTRS_RATE_RESET 4'h6
`define OTRS_CODE_MSB 3
`define OTRS_ENET_APLL_BIT 6
`define OTRS_ENET_SEL_BIT 2

// ============================================================
// divide ratios, seven bits wide
`define OTRS_DIV_NONE 7'h01
`define OTRS_DIV_M5 7'h30
`define OTRS_DIV_M6 7'h10
`define OTRS_DIV_M7 7'h0c
`define OTRS_DIV_M8 7'h08
`define OTRS_DIV_M9 7'h06
`define OTRS_DIV_M10 7'h04
`define OTRS_DIV_A11 7'h40
`define OTRS_DIV_A12 7'h20
`define OTRS_DIV_A13 7'h10
`define OTRS_DIV_A14 7'h08
`define OTRS_DIV_A15 7'h04

`endif

// *** verilog/otrs_pkg.sv ***
// types shared by the output three rate selector
package otrs_pkg;

    // ============================================================
    // source picked for output three
    typedef enum logic [2:0] {
        SRC_OFF = 3'h0,
        SRC_2K = 3'h1,
        SRC_8K = 3'h2,
        SRC_SYNTH_TWO = 3'h3,
        SRC_SYNTH_ONE = 3'h4,
        SRC_MAIN_DIV = 3'h5,
        SRC_AUX_DIV = 3'h6,
        SRC_ETHER = 3'h7
    } otrs_src_t;

    // ethernet rates
    typedef enum logic [1:0] {
        ETH_25M = 2'h0,
        ETH_50M = 2'h1,
        ETH_62M5 = 2'h2,
        ETH_125M = 2'h3
    } otrs_eth_t;

    // full selection handed to the clock mux
    typedef struct packed {
        otrs_src_t source;
        logic [6:0] divisor;
        otrs_eth_t ethRate;
        logic apllOn;
    } otrs_sel_t;

endpackage

// *** verilog/otrs_top.sv ***
// output three rate selector with its ahb-lite register slave
`timescale 1ns/1ns
`include "otrs_defines.svh"

module otrs_top (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // selection for the output three clock mux
    output otrs_pkg::otrs_sel_t outSel
);

    // ============================================================
    // code decode, shared by the selector and the status readback
    function automatic otrs_pkg::otrs_sel_t decodeSel(
        input logic [3:0] code,
        input logic ethSel,
        input logic apllOn
    );
        otrs_pkg::otrs_sel_t s;
        s.apllOn = apllOn;
        s.divisor = `OTRS_DIV_NONE;
        s.ethRate = otrs_pkg::otrs_eth_t'(code[1:0]);
        s.source = otrs_pkg::SRC_OFF;
        if (ethSel) begin
            // every code maps onto its low two bits
            s.source = otrs_pkg::SRC_ETHER;
        end else begin
            case (code)
                4'h0: s.source = otrs_pkg::SRC_OFF;
                4'h1: s.source = otrs_pkg::SRC_2K;
                4'h2: s.source = otrs_pkg::SRC_8K;
                4'h3: s.source = otrs_pkg::SRC_SYNTH_TWO;
                4'h4: s.source = otrs_pkg::SRC_SYNTH_ONE;
                4'h5: begin
                    s.source = otrs_pkg::SRC_MAIN_DIV;
                    s.divisor = `OTRS_DIV_M5;
                end
                4'h6: begin
                    s.source = otrs_pkg::SRC_MAIN_DIV;
                    s.divisor = `OTRS_DIV_M6;
                end
                4'h7: begin
                    s.source = otrs_pkg::SRC_MAIN_DIV;
                    s.divisor = `OTRS_DIV_M7;
                end
                4'h8: begin
                    s.source = otrs_pkg::SRC_MAIN_DIV;
                    s.divisor = `OTRS_DIV_M8;
                end
                4'h9: begin
                    s.source = otrs_pkg::SRC_MAIN_DIV;
                    s.divisor = `OTRS_DIV_M9;
                end
                4'ha: begin
                    s.source = otrs_pkg::SRC_MAIN_DIV;
                    s.divisor = `OTRS_DIV_M10;
                end
                4'hb: begin
                    s.source = otrs_pkg::SRC_AUX_DIV;
                    s.divisor = `OTRS_DIV_A11;
                end
                4'hc: begin
                    s.source = otrs_pkg::SRC_AUX_DIV;
                    s.divisor = `OTRS_DIV_A12;
                end
                4'hd: begin
                    s.source = otrs_pkg::SRC_AUX_DIV;
                    s.divisor = `OTRS_DIV_A13;
                end
                4'he: begin
                    s.source = otrs_pkg::SRC_AUX_DIV;
                    s.divisor = `OTRS_DIV_A14;
                end
                default: begin
                    s.source = otrs_pkg::SRC_AUX_DIV;
                    s.divisor = `OTRS_DIV_A15;
                end
            endcase
        end
        return s;
    endfunction

    // ============================================================
    // state
    logic [3:0] rateReg, rateNext;
    logic apllOnReg, apllOnNext;
    logic ethSelReg, ethSelNext;
    logic wrPendReg, wrPendNext;
    logic [7:0] wrAddrReg, wrAddrNext;
    logic [31:0] rdataReg, rdataNext;
    otrs_pkg::otrs_sel_t selReg, selNext;
    otrs_pkg::otrs_sel_t liveSel;
    logic addrPhase;
    logic [7:0] addrLow;

    // zero wait states, so the slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdataReg;
    assign outSel = selReg;
    assign addrPhase = hsel && htrans[1] && hready;
    assign addrLow = haddr[`OTRS_ADDR_MSB:0];
    assign liveSel = decodeSel(rateReg, ethSelReg, apllOnReg);

    // ============================================================
    // next values: bus write in data phase, read data from addr phase
    always_comb begin
        rateNext = rateReg;
        apllOnNext = apllOnReg;
        ethSelNext = ethSelReg;
        wrPendNext = addrPhase && hwrite;
        wrAddrNext = addrPhase ? addrLow : wrAddrReg;
        rdataNext = 32'h0000_0000;
        selNext = liveSel;
        if (wrPendReg) begin
            case (wrAddrReg)
                // bits above bit 3 dropped on write
                `OTRS_RATE_OFFSET: rateNext = hwdata[`OTRS_CODE_MSB:0];
                `OTRS_ENET_OFFSET: begin
                    apllOnNext = hwdata[`OTRS_ENET_APLL_BIT];
                    ethSelNext = hwdata[`OTRS_ENET_SEL_BIT];
                end
                default: ;
            endcase
        end
        if (addrPhase && !hwrite) begin
            case (addrLow)
                `OTRS_RATE_OFFSET: rdataNext[3:0] = rateReg;
                `OTRS_ENET_OFFSET: begin
                    rdataNext[`OTRS_ENET_APLL_BIT] = apllOnReg;
                    rdataNext[`OTRS_ENET_SEL_BIT] = ethSelReg;
                end
                `OTRS_STAT_OFFSET: rdataNext[12:0] = selReg;
                default: rdataNext = 32'h0000_0000;
            endcase
        end
    end

    // register stage; selection lags the register by one clock
    always_ff @(posedge clock) begin
        if (reset) begin
            rateReg <= `OTRS_RATE_RESET;
            apllOnReg <= 1'b0;
            ethSelReg <= 1'b0;
            wrPendReg <= 1'b0;
            wrAddrReg <= 8'h00;
            rdataReg <= 32'h0000_0000;
            selReg <= '0;
        end else begin
            rateReg <= rateNext;
            apllOnReg <= apllOnNext;
            ethSelReg <= ethSelNext;
            wrPendReg <= wrPendNext;
            wrAddrReg <= wrAddrNext;
            rdataReg <= rdataNext;
            selReg <= selNext;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_ETH_RATE: assert property ($past(ethSelReg) |->
        selReg.source == otrs_pkg::SRC_ETHER &&
        selReg.ethRate == otrs_pkg::otrs_eth_t'($past(rateReg[1:0])))
        else $error("ethernet rate not taken from code");
    AST_LOW_RATES: assert property (!$past(ethSelReg) |->
        ($past(rateReg) == 4'h0 -> selReg.source == otrs_pkg::SRC_OFF) &&
        ($past(rateReg) == 4'h1 -> selReg.source == otrs_pkg::SRC_2K) &&
        ($past(rateReg) == 4'h2 -> selReg.source == otrs_pkg::SRC_8K))
        else $error("low rate code misdecoded");
    AST_SYNTH: assert property (!$past(ethSelReg) |->
        ($past(rateReg) == 4'h3 -> selReg.source == otrs_pkg::SRC_SYNTH_TWO)
        && ($past(rateReg) == 4'h4 ->
        selReg.source == otrs_pkg::SRC_SYNTH_ONE))
        else $error("synthesizer code misdecoded");
    AST_MAIN_DIV: assert property (!$past(ethSelReg) &&
        $past(rateReg) inside {[4'h7:4'ha]} |->
        selReg.source == otrs_pkg::SRC_MAIN_DIV &&
        selReg.divisor == ($past(rateReg) == 4'h7 ? `OTRS_DIV_M7 :
        $past(rateReg) == 4'h8 ? `OTRS_DIV_M8 :
        $past(rateReg) == 4'h9 ? `OTRS_DIV_M9 : `OTRS_DIV_M10))
        else $error("main path divisor wrong");
    AST_AUX_DIV: assert property (!$past(ethSelReg) &&
        $past(rateReg) >= 4'hb |->
        selReg.source == otrs_pkg::SRC_AUX_DIV)
        else $error("aux path not selected");
    AST_APLL: assert property ($changed(apllOnReg) |=>
        selReg.apllOn == $past(apllOnReg))
        else $error("ethernet apll enable not followed");
    AST_MAP_SWITCH: assert property ($rose(ethSelReg) |->
        selReg.source != otrs_pkg::SRC_ETHER || $past(ethSelReg, 2)
        ##1 selReg.source == otrs_pkg::SRC_ETHER)
        else $error("mapping switch late");
    AST_UNUSED: assert property ($past(addrPhase && !hwrite &&
        addrLow == `OTRS_RATE_OFFSET) |-> hrdata[31:4] == 28'h0000000)
        else $error("unused rate bits read nonzero");
    AST_WRITE: assert property (wrPendReg &&
        wrAddrReg == `OTRS_RATE_OFFSET |=> rateReg == $past(hwdata[3:0]))
        else $error("rate write lost");
    // ethernet config write lands both control bits one edge later
    AST_ENET_WRITE: assert property (wrPendReg &&
        wrAddrReg == `OTRS_ENET_OFFSET |=>
        ethSelReg == $past(hwdata[`OTRS_ENET_SEL_BIT]) &&
        apllOnReg == $past(hwdata[`OTRS_ENET_APLL_BIT]))
        else $error("ethernet config write lost");
    // status readback shows the selection of the address phase
    AST_STATUS: assert property ($past(addrPhase && !hwrite &&
        addrLow == `OTRS_STAT_OFFSET) |-> hrdata == {19'h0, $past(selReg)})
        else $error("status readback differs from selection");

endmodule // otrs_top
